// ===== bodreg_top.v
// supply drop detector register bank with warning monitor, AXI4-Lite slave
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "bodreg_defs.vh"

module bodreg_top #(
    parameter FAST_CYC = `BODREG_FAST_CYC,
    parameter SLOW_CYC = `BODREG_SLOW_CYC
) (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // fuse configuration
    input  wire [7:0]  fuse_cfg,
    // axi4-lite write address
    input  wire [5:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [5:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // power state and analog side
    input  wire        sleep_deep,
    input  wire        supply_below_warn,
    input  wire        detector_ready,
    output reg  [1:0]  detector_mode,
    output reg         detector_sample,
    output reg         monitor_enable,
    output reg  [1:0]  warning_margin,
    output reg  [2:0]  threshold_code,
    output reg         halt_execution,
    output reg         warning_irq
);

    // ------------------------------------------------------------------------
    // fuse-loaded and software registers
    // ------------------------------------------------------------------------
    reg        sample_rate_select_r;
    reg [1:0]  awake_mode_r;
    reg [1:0]  standby_mode_r;
    reg [1:0]  warning_direction_r;
    reg        warning_irq_enable_r;
    reg        warning_irq_flag_r;
    reg        warning_below_status_r;
    reg [2:0]  unlock_cnt_r;
    reg        fuse_load_r;
    reg        sleep_q_r;

    // comparator and power-state inputs are asynchronous: three stages,
    // and a change counts only once stages two and three agree
    wire [2:0] async_in = {detector_ready, sleep_deep, supply_below_warn};
    wire [2:0] synced;
    genvar     gi;

    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            reg [2:0] stage_r;
            reg       level_r;
            always @(posedge aclk) begin
                if (!aresetn) begin
                    stage_r <= 3'h0;
                    level_r <= 1'b0;
                end else begin
                    stage_r <= {stage_r[1:0], async_in[gi]};
                    if (stage_r[1] == stage_r[2])
                        level_r <= stage_r[2];
                end
            end
            assign synced[gi] = level_r;
        end
    endgenerate

    wire       below_r = synced[0];
    wire       deep_r  = synced[1];
    wire       ready_r = synced[2];

    // ------------------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------------------
    reg        aw_have_r;
    reg        w_have_r;
    reg [3:0]  aw_idx_r;
    reg [7:0]  w_byte_r;
    reg        w_lane_r;
    wire       wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
    wire       wr_byte = wr_fire && w_lane_r && (aw_idx_r <= `BODREG_IDX_UNLOCK);
    wire       wr_mode = wr_byte && (aw_idx_r == `BODREG_IDX_MODE);
    wire       guard_open = (unlock_cnt_r != 3'h0);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            aw_idx_r      <= 4'h0;
            w_byte_r      <= 8'h00;
            w_lane_r      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `BODREG_RESP_OKAY;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && !aw_have_r && !s_axi_awready) begin
                s_axi_awready <= 1'b1;
                aw_have_r     <= 1'b1;
                aw_idx_r      <= s_axi_awaddr[5:2];
            end
            if (s_axi_wvalid && !w_have_r && !s_axi_wready) begin
                s_axi_wready <= 1'b1;
                w_have_r     <= 1'b1;
                w_byte_r     <= s_axi_wdata[7:0];
                w_lane_r     <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // unmapped offsets answer slverr, reserved ones okay
                s_axi_bresp  <= (aw_idx_r > `BODREG_IDX_UNLOCK) ?
                                `BODREG_RESP_SLVERR : `BODREG_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // register updates
    // ------------------------------------------------------------------------
    reg        trigger;
    reg        flag_nxt;
    reg [23:0] rate_cnt_r;
    wire [1:0] wr_stby   = w_byte_r[`BODREG_STBY_HI:`BODREG_STBY_LO];
    wire [1:0] wr_lvl    = w_byte_r[`BODREG_MARGIN_HI:`BODREG_MARGIN_LO];
    wire       wr_flags  = wr_byte && (aw_idx_r == `BODREG_IDX_FLAGS);
    wire       wr_margin = wr_byte && (aw_idx_r == `BODREG_IDX_MARGIN);
    wire       wr_intctl = wr_byte && (aw_idx_r == `BODREG_IDX_INTERRUPT_CONTROL);
    wire       wr_unlock = wr_byte && (aw_idx_r == `BODREG_IDX_UNLOCK) &&
                           (w_byte_r == `BODREG_UNLOCK_KEY);
    wire       below_prev_diff = (below_r != warning_below_status_r);
    // continuous mode looks every cycle, sampled mode only on the tick
    wire       sample_now = (detector_mode != `BODREG_MODE_SAMP) ||
                            (rate_cnt_r == 24'h0);

    always @* begin
        case (warning_direction_r)
            `BODREG_DIR_BELOW: trigger = below_prev_diff && below_r;
            `BODREG_DIR_ABOVE: trigger = below_prev_diff && !below_r;
            `BODREG_DIR_CROSS: trigger = below_prev_diff;
            default:           trigger = 1'b0;
        endcase
        flag_nxt = warning_irq_flag_r;
        if (wr_flags && w_byte_r[`BODREG_IF_BIT])
            flag_nxt = 1'b0;
        // set beats clear in the same cycle so no warning is lost
        if (trigger && monitor_enable && sample_now)
            flag_nxt = 1'b1;
    end

    // read-only fields, caught from the fuses on the first clock after release
    always @(posedge aclk) begin
        if (!aresetn) begin
            fuse_load_r          <= 1'b1;
            sample_rate_select_r <= 1'b0;
            awake_mode_r         <= `BODREG_MODE_OFF;
            threshold_code       <= 3'h0;
        end else if (fuse_load_r) begin
            fuse_load_r          <= 1'b0;
            sample_rate_select_r <= fuse_cfg[`BODREG_RATE_BIT];
            awake_mode_r         <=
                fuse_cfg[`BODREG_AWAKE_HI:`BODREG_AWAKE_LO];
            threshold_code       <=
                fuse_cfg[`BODREG_FUSE_LVL_HI:`BODREG_FUSE_LVL_LO];
        end
    end

    // standby field: fuse value on the first clock after reset, then guarded software writes
    always @(posedge aclk) begin
        if (!aresetn) begin
            standby_mode_r <= `BODREG_MODE_OFF;
        end else if (fuse_load_r) begin
            standby_mode_r <=
                fuse_cfg[`BODREG_STBY_HI:`BODREG_STBY_LO];
        end else if (wr_mode && guard_open &&
                     wr_stby != `BODREG_MODE_HALTWAKE) begin
            standby_mode_r <= wr_stby;
        end
    end

    // the unlock window counts bus writes, standing in for instructions
    always @(posedge aclk) begin
        if (!aresetn) begin
            unlock_cnt_r <= 3'h0;
        end else if (wr_unlock) begin
            unlock_cnt_r <= `BODREG_UNLOCK_WIN;
        end else if (wr_fire && guard_open) begin
            unlock_cnt_r <= unlock_cnt_r - 3'h1;
        end
    end

    // reserved margin codes are dropped so the analog side never sees them
    always @(posedge aclk) begin
        if (!aresetn) begin
            warning_margin <= 2'h0;
        end else if (wr_margin && wr_lvl <= `BODREG_MARGIN_MAX) begin
            warning_margin <= wr_lvl;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            warning_irq_enable_r <= 1'b0;
            warning_direction_r  <= `BODREG_DIR_BELOW;
        end else if (wr_intctl) begin
            warning_irq_enable_r <= w_byte_r[`BODREG_IE_BIT];
            warning_direction_r  <=
                w_byte_r[`BODREG_DIR_HI:`BODREG_DIR_LO];
        end
    end

    // status only moves while the detector actually looks at the supply
    always @(posedge aclk) begin
        if (!aresetn) begin
            warning_irq_flag_r     <= 1'b0;
            warning_below_status_r <= 1'b0;
        end else begin
            warning_irq_flag_r <= flag_nxt;
            if (monitor_enable && sample_now)
                warning_below_status_r <= below_r;
        end
    end

    // ------------------------------------------------------------------------
    // detector mode, sampling and hold after wake
    // ------------------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            detector_mode  <= `BODREG_MODE_OFF;
            monitor_enable <= 1'b0;
        end else begin
            if (deep_r) begin
                // a reserved standby code from the fuses keeps the detector off
                detector_mode <= (standby_mode_r == `BODREG_MODE_HALTWAKE) ?
                                 `BODREG_MODE_OFF : standby_mode_r;
            end else begin
                detector_mode <= (awake_mode_r == `BODREG_MODE_HALTWAKE) ?
                                 `BODREG_MODE_CONT : awake_mode_r;
            end
            monitor_enable <= (detector_mode != `BODREG_MODE_OFF);
        end
    end

    // a slow rate only saves power; the period comes from one counter
    always @(posedge aclk) begin
        if (!aresetn) begin
            rate_cnt_r      <= 24'h0;
            detector_sample <= 1'b0;
        end else begin
            if (rate_cnt_r == 24'h0)
                rate_cnt_r <= sample_rate_select_r ?
                              SLOW_CYC[23:0] - 24'h1 :
                              FAST_CYC[23:0] - 24'h1;
            else
                rate_cnt_r <= rate_cnt_r - 24'h1;
            detector_sample <= (detector_mode == `BODREG_MODE_SAMP) &&
                               (rate_cnt_r == 24'h0);
        end
    end

    // the hold is armed by the wake edge, so a halt never starts mid-run
    always @(posedge aclk) begin
        if (!aresetn) begin
            sleep_q_r      <= 1'b0;
            halt_execution <= 1'b0;
        end else begin
            sleep_q_r <= deep_r;
            if (sleep_q_r && !deep_r &&
                awake_mode_r == `BODREG_MODE_HALTWAKE)
                halt_execution <= 1'b1;
            else if (ready_r)
                halt_execution <= 1'b0;
        end
    end

    // built from the next flag value so the request rises with the flag
    always @(posedge aclk) begin
        if (!aresetn)
            warning_irq <= 1'b0;
        else
            warning_irq <= warning_irq_enable_r && flag_nxt;
    end

    // ------------------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------------------
    reg [7:0] rd_byte;
    always @* begin
        rd_byte = 8'h00;
        case (s_axi_araddr[5:2])
            `BODREG_IDX_MODE:    rd_byte = {3'h0, sample_rate_select_r,
                                            awake_mode_r, standby_mode_r};
            `BODREG_IDX_LEVEL:   rd_byte = {5'h00, threshold_code};
            `BODREG_IDX_MARGIN:  rd_byte = {6'h00, warning_margin};
            `BODREG_IDX_INTERRUPT_CONTROL: rd_byte = {5'h00, warning_direction_r,
                                            warning_irq_enable_r};
            `BODREG_IDX_FLAGS:   rd_byte = {7'h00, warning_irq_flag_r};
            `BODREG_IDX_STATUS:  rd_byte = {7'h00, warning_below_status_r};
            default:             rd_byte = 8'h00;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `BODREG_RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h000000, rd_byte};
                s_axi_rresp   <= (s_axi_araddr[5:2] > `BODREG_IDX_UNLOCK) ?
                                 `BODREG_RESP_SLVERR : `BODREG_RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ===== bodreg_defs.vh
// register offsets, field positions and timing constants of the supply monitor bank
`ifndef BODREG_DEFS_VH
`define BODREG_DEFS_VH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define BODREG_IDX_MODE      4'h0
`define BODREG_IDX_LEVEL     4'h1
`define BODREG_IDX_MARGIN    4'h8
`define BODREG_IDX_INTERRUPT_CONTROL   4'h9
`define BODREG_IDX_FLAGS     4'hA
`define BODREG_IDX_STATUS    4'hB
`define BODREG_IDX_UNLOCK    4'hC

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define BODREG_RATE_BIT      4
`define BODREG_AWAKE_HI      3
`define BODREG_AWAKE_LO      2
`define BODREG_STBY_HI       1
`define BODREG_STBY_LO       0
`define BODREG_LVL_HI        2
`define BODREG_DIR_HI        2
`define BODREG_DIR_LO        1
`define BODREG_IE_BIT        0
`define BODREG_IF_BIT        0
`define BODREG_MARGIN_HI     1
`define BODREG_MARGIN_LO     0
`define BODREG_FUSE_LVL_HI   7
`define BODREG_FUSE_LVL_LO   5

// ----------------------------------------------------------------------------
// encodings
// ----------------------------------------------------------------------------
`define BODREG_MODE_OFF      2'h0
`define BODREG_MODE_CONT     2'h1
`define BODREG_MODE_SAMP     2'h2
`define BODREG_MODE_HALTWAKE 2'h3
`define BODREG_DIR_BELOW     2'h0
`define BODREG_DIR_ABOVE     2'h1
`define BODREG_DIR_CROSS     2'h2
`define BODREG_MARGIN_MAX    2'h2
`define BODREG_UNLOCK_KEY    8'hD8
`define BODREG_UNLOCK_WIN    3'h4
`define BODREG_RESP_OKAY     2'h0
`define BODREG_RESP_SLVERR   2'h2

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define BODREG_CLK_HZ        100000000
`define BODREG_FAST_HZ       1000
`define BODREG_SLOW_HZ       125
`define BODREG_FAST_CYC      (`BODREG_CLK_HZ / `BODREG_FAST_HZ)
`define BODREG_SLOW_CYC      (`BODREG_CLK_HZ / `BODREG_SLOW_HZ)

`endif

// ===== bodreg_properties.sv
// checker for the supply monitor register bank outputs
`timescale 1ns/10ps
`default_nettype none
module bodreg_props (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus handshakes
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // analog side
    input wire logic [1:0]  detector_mode,
    input wire logic        detector_sample,
    input wire logic        monitor_enable,
    input wire logic [1:0]  warning_margin,
    input wire logic [2:0]  threshold_code,
    input wire logic        halt_execution,
    input wire logic        warning_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    mon_follow_a: assert property (monitor_enable == ($past(detector_mode) != 2'h0))
        else $error("monitor enable disagrees with detector mode");
    mode_legal_a: assert property (detector_mode != 2'h3)
        else $error("detector mode shows reserved code");
    samp_only_a: assert property (detector_sample |-> $past(detector_mode) == 2'h2)
        else $error("sample tick outside sampled mode");
    samp_pulse_a: assert property (detector_sample |=> !detector_sample)
        else $error("sample tick longer than one cycle");
    level_fixed_a: assert property (aresetn && $past(aresetn, 3) |-> $stable(threshold_code))
        else $error("threshold code changed after load");
    margin_legal_a: assert property (warning_margin != 2'h3)
        else $error("reserved margin reached the monitor");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("unused read bits not zero");
    write_resp_a: assert property (s_axi_awready && s_axi_wready |=> s_axi_bvalid)
        else $error("write response late");
    cover property (detector_sample);
    cover property ($rose(warning_irq));
    cover property ($rose(halt_execution));
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind bodreg_top bodreg_props u_bodreg_props (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .detector_mode(detector_mode), .detector_sample(detector_sample),
    .monitor_enable(monitor_enable), .warning_margin(warning_margin),
    .threshold_code(threshold_code), .halt_execution(halt_execution),
    .warning_irq(warning_irq));
`default_nettype wire

// ===== bodreg_bench.sv
// self-checking bench for the supply monitor register bank
`timescale 1ns/10ps
`default_nettype none
module bodreg_bench;
    localparam SLOW = 64;
    localparam FAST = 8;
    logic        aclk = 1'h0;
    logic        aresetn = 1'h0;
    logic [7:0]  fuse_cfg = 8'hB9;
    logic [5:0]  awaddr = 6'h0, araddr = 6'h0;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic        arvalid = 1'h0, rready = 1'h0;
    logic        sleep_deep = 1'h0, below = 1'h0, det_rdy = 1'h0;
    wire         awready, wready, bvalid, arready, rvalid;
    wire         sample, mon_en, halt, irq;
    wire  [1:0]  bresp, rresp, det_mode, margin;
    wire  [2:0]  thr;
    wire  [31:0] rdata;
    logic [31:0] rd_d;
    logic [1:0]  rsp;
    int          err_total = 0, checked = 0, cyc = 0, n;

    always #5 aclk = ~aclk;

    bodreg_top #(.FAST_CYC(FAST), .SLOW_CYC(SLOW)) u_bodreg_top (
        .aclk(aclk), .aresetn(aresetn), .fuse_cfg(fuse_cfg),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sleep_deep(sleep_deep),
        .supply_below_warn(below), .detector_ready(det_rdy),
        .detector_mode(det_mode), .detector_sample(sample),
        .monitor_enable(mon_en), .warning_margin(margin),
        .threshold_code(thr), .halt_execution(halt), .warning_irq(irq));

    task stop_test;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // hangs end here; the whole run needs well under this many cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            stop_test;
        end
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task wr(input logic [3:0] i, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= {i, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
        rsp = bresp;
    endtask

    task rd(input logic [3:0] i, input logic [7:0] e);
        @(posedge aclk);
        araddr <= {i, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rready <= 1'h0;
        rsp = rresp;
        chk("read data", {24'h0, e}, rdata);
    endtask

    task t_reset(input logic [7:0] f);
        fuse_cfg <= f;
        aresetn <= 1'h0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (6) @(posedge aclk);
    endtask

    // fuse byte B9: level 5, slow rate, awake sampled, standby continuous
    task t_fuse;
        rd(4'h0, 8'h19);
        rd(4'h1, 8'h05);
        chk("level out", 32'h5, {29'h0, thr});
        for (int i = 8; i < 12; i++) rd(i[3:0], 8'h00);
        chk("awake mode", 32'h2, {30'h0, det_mode});
        chk("monitor on", 32'h1, {31'h0, mon_en});
    endtask

    // shortened counts give a tick every FAST or SLOW cycles
    task t_rate(input int p);
        n = 0;
        while (!sample && n < 200) begin
            @(posedge aclk);
            n++;
        end
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (!sample && n < 200);
        chk("sample period", p, n);
    endtask

    task t_guard;
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h19);
        wr(4'hC, 8'hD8);
        wr(4'h0, 8'h1F);
        rd(4'h0, 8'h19);
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h18);
        wr(4'h9, 8'h05);
        sleep_deep <= 1'h1;
        repeat (8) @(posedge aclk);
        chk("sleep mode", 32'h0, {30'h0, det_mode});
        chk("monitor off", 32'h0, {31'h0, mon_en});
        below <= 1'h1;
        repeat (SLOW + 16) @(posedge aclk);
        rd(4'hA, 8'h00);
        below <= 1'h0;
        sleep_deep <= 1'h0;
        repeat (8) @(posedge aclk);
        chk("wake mode", 32'h2, {30'h0, det_mode});
        rd(4'h4, 8'h00);
        chk("reserved resp", 32'h0, {30'h0, rsp});
        wr(4'h5, 8'hFF);
        rd(4'h5, 8'h00);
        rd(4'hD, 8'h00);
        chk("unmapped resp", 32'h2, {30'h0, rsp});
        wr(4'hD, 8'hFF);
        chk("unmapped wresp", 32'h2, {30'h0, rsp});
    endtask

    task t_margin;
        wr(4'h8, 8'h03);
        rd(4'h8, 8'h00);
        wr(4'h8, 8'h02);
        rd(4'h8, 8'h02);
        chk("margin out", 32'h2, {30'h0, margin});
    endtask

    // a long wait covers sync delay plus one full sample period
    task t_flag;
        wr(4'h9, 8'h01);
        below <= 1'h1;
        repeat (SLOW + 16) @(posedge aclk);
        rd(4'hA, 8'h01);
        rd(4'hB, 8'h01);
        chk("irq on", 32'h1, {31'h0, irq});
        wr(4'hA, 8'h00);
        rd(4'hA, 8'h01);
        wr(4'hA, 8'h01);
        rd(4'hA, 8'h00);
        chk("irq off", 32'h0, {31'h0, irq});
        wr(4'h9, 8'h03);
        below <= 1'h0;
        repeat (SLOW + 16) @(posedge aclk);
        rd(4'hA, 8'h01);
        wr(4'hA, 8'h01);
        below <= 1'h1;
        repeat (SLOW + 16) @(posedge aclk);
        rd(4'hA, 8'h00);
        rd(4'hB, 8'h01);
    endtask

    // awake code 3 must hold execution after wake until the detector runs
    task t_halt;
        t_reset(8'h0C);
        chk("halt awake", 32'h1, {30'h0, det_mode});
        sleep_deep <= 1'h1;
        repeat (8) @(posedge aclk);
        sleep_deep <= 1'h0;
        repeat (8) @(posedge aclk);
        chk("halt set", 32'h1, {31'h0, halt});
        det_rdy <= 1'h1;
        repeat (8) @(posedge aclk);
        chk("halt clear", 32'h0, {31'h0, halt});
    endtask

    initial begin
        t_reset(8'hB9);
        t_fuse;
        t_rate(SLOW);
        t_guard;
        t_margin;
        t_flag;
        t_reset(8'h08);
        t_rate(FAST);
        t_halt;
        stop_test;
    end
endmodule
`default_nettype wire
